// file: hw/status_telemetry_pkg.sv
// status_telemetry_pkg: command selectors, flag positions, reset values and carriers
// for the status and telemetry read-back block; shared by design and bench.
package status_telemetry_pkg;

    // command selectors on the read-back port
    localparam logic [2:0] CMD_VENDOR_STATUS = 3'h0;
    localparam logic [2:0] CMD_READ_VIN = 3'h1;
    localparam logic [2:0] CMD_READ_VOUT = 3'h2;
    localparam logic [2:0] CMD_READ_TEMP = 3'h3;
    localparam logic [2:0] CMD_BUS_REVISION = 3'h4;

    // bit positions in the vendor status byte
    localparam int BIT_DISCHARGE = 7;
    localparam int BIT_FAULT_ONE = 6;
    localparam int BIT_FAULT_ZERO = 5;
    localparam int BIT_SERVO_REACHED = 4;
    localparam int BIT_DAC_CONNECTED = 3;
    localparam int BIT_DAC_SATURATED = 2;
    localparam int BIT_VINEN_OFF = 1;
    localparam int BIT_WATCHDOG = 0;

    // linear format field layout
    localparam int L11_MANT_W = 11;
    localparam int L11_EXP_W = 5;
    localparam int WORD_W = 16;

    // values after reset
    localparam logic [15:0] READING_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;

    // per-channel sticky flags
    typedef struct packed {
        logic discharge;
        logic fault_one;
        logic fault_zero;
        logic dac_saturated;
    } ch_flags_s;

    localparam ch_flags_s CH_FLAGS_RESET = '{discharge: 1'b0, fault_one: 1'b0,
        fault_zero: 1'b0, dac_saturated: 1'b0};

    // one linear reading: 5-bit exponent and 11-bit mantissa, both two's complement
    typedef struct packed {
        logic [4:0] exponent;
        logic [10:0] mantissa;
    } l11_s;

endpackage

// file: hw/status_telemetry_readback.sv
// status_telemetry_readback: vendor status byte, latest ADC readings and bus revision
// for a multi-channel power manager, answered on a simple command read-back port.
// assumes event and reading inputs come from logic on clk_sys_i; the shared fault
// lines come from pins and are synchronised here.
`timescale 1ns/1ns
`default_nettype none
module status_telemetry_readback
    import status_telemetry_pkg::*;
#(
    parameter int CHANNELS = 8,
    parameter int PAGE_W = 3,
    // arbitrary neutral value for the reported revision code
    parameter logic [7:0] BUS_REVISION_CODE = 8'h2a
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic shared_fault_line_one_i,
    input wire logic shared_fault_line_zero_i,
    input wire logic [CHANNELS-1:0] discharge_fault_i,
    input wire logic [CHANNELS-1:0] turn_on_attempt_i,
    input wire logic [CHANNELS-1:0] shutdown_by_line_one_i,
    input wire logic [CHANNELS-1:0] shutdown_by_line_zero_i,
    input wire logic [CHANNELS-1:0] control_toggle_i,
    input wire logic [CHANNELS-1:0] operation_cycle_i,
    input wire logic [CHANNELS-1:0] user_on_cmd_i,
    input wire logic clear_faults_i,
    input wire logic [CHANNELS-1:0] servo_reached_i,
    input wire logic [CHANNELS-1:0] dac_connected_i,
    input wire logic [CHANNELS-1:0] dac_saturated_i,
    input wire logic vinen_faulted_off_i,
    input wire logic watchdog_fault_i,
    input wire logic [CHANNELS-1:0] discharge_off_en_i,
    input wire logic [CHANNELS-1:0] fault_one_off_en_i,
    input wire logic [CHANNELS-1:0] fault_zero_off_en_i,
    input wire logic [CHANNELS-1:0] adc_hires_i,
    input wire logic vin_valid_i,
    input wire l11_s vin_sample_i,
    input wire logic temp_valid_i,
    input wire l11_s temp_sample_i,
    input wire logic vout_valid_i,
    input wire logic [PAGE_W-1:0] vout_chan_i,
    input wire logic [15:0] vout_l16_i,
    input wire l11_s vout_current_i,
    input wire logic rd_req_i,
    input wire logic [2:0] rd_cmd_i,
    input wire logic [PAGE_W-1:0] rd_page_i,
    input wire logic wr_req_i,
    input wire logic [2:0] wr_cmd_i,
    output logic [15:0] rd_data_o,
    output logic rd_valid_o,
    output logic rd_err_o,
    output logic wr_refused_o,
    output logic alert_output_low_o,
    output logic [CHANNELS-1:0] shutdown_req_o
);

    // pack exponent into the upper bits and mantissa into the lower bits
    function automatic logic [15:0] pack_l11(input l11_s v);
        pack_l11 = {v.exponent, v.mantissa};
    endfunction

    logic fl_one_meta_reg, fl_one_sync_reg, fl_zero_meta_reg, fl_zero_sync_reg;
    ch_flags_s flags_reg [CHANNELS];
    ch_flags_s flags_next [CHANNELS];
    logic watchdog_reg, watchdog_next;
    logic alert_n_reg, alert_n_next;
    logic [CHANNELS-1:0] shutdown_reg, shutdown_next;
    logic [15:0] vin_reg, vin_next, temp_reg, temp_next;
    logic [15:0] vout_reg [CHANNELS];
    logic [15:0] vout_next [CHANNELS];
    logic [15:0] data_reg, data_next;
    logic valid_reg, valid_next, err_reg, err_next, refused_reg, refused_next;
    // per-channel alerting summary rebuilt from the flag registers for the alert check
    wire logic [CHANNELS-1:0] alerting_vec;

    always_comb begin
        ch_flags_s f;
        logic any_alert;
        logic [7:0] status;
        f = CH_FLAGS_RESET;
        any_alert = 1'b0;
        status = 8'h00;
        watchdog_next = watchdog_reg;
        if (clear_faults_i) begin
            watchdog_next = 1'b0;
        end
        watchdog_next = watchdog_next | watchdog_fault_i;
        any_alert = watchdog_next;
        for (int c = 0; c < CHANNELS; c++) begin
            f = flags_reg[c];
            if (clear_faults_i || user_on_cmd_i[c]) begin
                f = CH_FLAGS_RESET;
            end
            if (control_toggle_i[c] || operation_cycle_i[c] || clear_faults_i) begin
                f.fault_one = 1'b0;
                f.fault_zero = 1'b0;
            end
            // events win over any clear in the same cycle
            f.discharge = f.discharge | discharge_fault_i[c];
            f.fault_one = f.fault_one | shutdown_by_line_one_i[c]
                | (turn_on_attempt_i[c] & ~fl_one_sync_reg);
            f.fault_zero = f.fault_zero | shutdown_by_line_zero_i[c]
                | (turn_on_attempt_i[c] & ~fl_zero_sync_reg);
            f.dac_saturated = f.dac_saturated | dac_saturated_i[c];
            flags_next[c] = f;
            any_alert = any_alert | f.discharge | f.fault_one | f.fault_zero;
            // shutdown request pulses when an enabled flag newly sets
            shutdown_next[c] = (f.discharge & ~flags_reg[c].discharge & discharge_off_en_i[c])
                | (f.fault_one & ~flags_reg[c].fault_one & fault_one_off_en_i[c])
                | (f.fault_zero & ~flags_reg[c].fault_zero & fault_zero_off_en_i[c]);
            vout_next[c] = vout_reg[c];
            if (vout_valid_i && (int'(vout_chan_i) == c)) begin
                if ((c % 2 == 1) && adc_hires_i[c]) begin
                    vout_next[c] = pack_l11(vout_current_i);
                end else begin
                    vout_next[c] = vout_l16_i;
                end
            end
        end
        alert_n_next = ~any_alert;
        vin_next = vin_valid_i ? pack_l11(vin_sample_i) : vin_reg;
        temp_next = temp_valid_i ? pack_l11(temp_sample_i) : temp_reg;

        valid_next = rd_req_i;
        err_next = 1'b0;
        data_next = data_reg;
        if (rd_req_i) begin
            data_next = DATA_RESET;
            if (int'(rd_page_i) >= CHANNELS) begin
                err_next = 1'b1;
            end else begin
                case (rd_cmd_i)
                    CMD_VENDOR_STATUS: begin
                        status[BIT_DISCHARGE] = flags_reg[rd_page_i].discharge;
                        status[BIT_FAULT_ONE] = flags_reg[rd_page_i].fault_one;
                        status[BIT_FAULT_ZERO] = flags_reg[rd_page_i].fault_zero;
                        status[BIT_SERVO_REACHED] = servo_reached_i[rd_page_i];
                        status[BIT_DAC_CONNECTED] = dac_connected_i[rd_page_i];
                        status[BIT_DAC_SATURATED] = flags_reg[rd_page_i].dac_saturated;
                        status[BIT_VINEN_OFF] = vinen_faulted_off_i;
                        status[BIT_WATCHDOG] = watchdog_reg;
                        data_next = {8'h00, status};
                    end
                    CMD_READ_VIN: begin
                        data_next = vin_reg;
                    end
                    CMD_READ_VOUT: begin
                        data_next = vout_reg[rd_page_i];
                    end
                    CMD_READ_TEMP: begin
                        data_next = temp_reg;
                    end
                    CMD_BUS_REVISION: begin
                        data_next = {8'h00, BUS_REVISION_CODE};
                    end
                    default: begin
                        err_next = 1'b1;
                    end
                endcase
            end
        end
        // every command here is read only; a write only reports refusal
        refused_next = wr_req_i;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fl_one_meta_reg <= 1'b1;
            fl_one_sync_reg <= 1'b1;
            fl_zero_meta_reg <= 1'b1;
            fl_zero_sync_reg <= 1'b1;
            for (int c = 0; c < CHANNELS; c++) begin
                flags_reg[c] <= CH_FLAGS_RESET;
                vout_reg[c] <= READING_RESET;
            end
            watchdog_reg <= 1'b0;
            alert_n_reg <= 1'b1;
            shutdown_reg <= '0;
            vin_reg <= READING_RESET;
            temp_reg <= READING_RESET;
            data_reg <= DATA_RESET;
            valid_reg <= 1'b0;
            err_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            fl_one_meta_reg <= shared_fault_line_one_i;
            fl_one_sync_reg <= fl_one_meta_reg;
            fl_zero_meta_reg <= shared_fault_line_zero_i;
            fl_zero_sync_reg <= fl_zero_meta_reg;
            for (int c = 0; c < CHANNELS; c++) begin
                flags_reg[c] <= flags_next[c];
                vout_reg[c] <= vout_next[c];
            end
            watchdog_reg <= watchdog_next;
            alert_n_reg <= alert_n_next;
            shutdown_reg <= shutdown_next;
            vin_reg <= vin_next;
            temp_reg <= temp_next;
            data_reg <= data_next;
            valid_reg <= valid_next;
            err_reg <= err_next;
            refused_reg <= refused_next;
        end
    end

    assign rd_data_o = data_reg;
    assign rd_valid_o = valid_reg;
    assign rd_err_o = err_reg;
    assign wr_refused_o = refused_reg;
    assign alert_output_low_o = alert_n_reg;
    assign shutdown_req_o = shutdown_reg;

    for (genvar g = 0; g < CHANNELS; g++) begin : g_chk
        assign alerting_vec[g] = flags_reg[g].discharge | flags_reg[g].fault_one | flags_reg[g].fault_zero;
        AST_DISCHARGE_SETS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
            discharge_fault_i[g] |=> flags_reg[g].discharge && !alert_output_low_o)
            else $error("discharge event did not set flag and alert");
        AST_LINE_ONE_SHUTDOWN: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
            shutdown_by_line_one_i[g] |=> flags_reg[g].fault_one)
            else $error("line one shutdown not recorded");
        AST_PIN_FLAGS_CLEARED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
            control_toggle_i[g] && !turn_on_attempt_i[g] && !shutdown_by_line_one_i[g]
            && !shutdown_by_line_zero_i[g] |=> !flags_reg[g].fault_one && !flags_reg[g].fault_zero)
            else $error("pin flags survived a control toggle");
        AST_STICKY_HOLDS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
            flags_reg[g].discharge && !clear_faults_i && !user_on_cmd_i[g] |=> flags_reg[g].discharge)
            else $error("sticky discharge flag dropped");
        AST_SATURATED_SETS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
            dac_saturated_i[g] |=> flags_reg[g].dac_saturated ##1 flags_reg[g].dac_saturated
            || $past(clear_faults_i) || $past(user_on_cmd_i[g]))
            else $error("saturation flag not kept");
        AST_LINE_ZERO_TURN_ON: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
            turn_on_attempt_i[g] && !fl_zero_sync_reg |=> flags_reg[g].fault_zero && !alert_output_low_o)
            else $error("turn-on against low line zero not recorded");
        AST_LINE_ZERO_SHUTDOWN: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
            shutdown_by_line_zero_i[g] && !flags_reg[g].fault_zero && fault_zero_off_en_i[g] |=> shutdown_req_o[g])
            else $error("line zero shutdown not requested");
        AST_CYCLE_CLEARS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
            operation_cycle_i[g] && !turn_on_attempt_i[g] && !shutdown_by_line_one_i[g]
            && !shutdown_by_line_zero_i[g] |=> !flags_reg[g].fault_one && !flags_reg[g].fault_zero)
            else $error("pin flags survived an on/off cycle");
        AST_DISCHARGE_OFF: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
            discharge_fault_i[g] && !flags_reg[g].discharge && discharge_off_en_i[g] |=> shutdown_req_o[g])
            else $error("discharge shutdown not requested");
        AST_USER_ON_CLEARS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
            user_on_cmd_i[g] && !discharge_fault_i[g] && !dac_saturated_i[g]
            |=> !flags_reg[g].discharge && !flags_reg[g].dac_saturated)
            else $error("user turn-on left sticky flags set");
        AST_VOUT_READBACK: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
            vout_valid_i && int'(vout_chan_i) == g ##1 (rd_req_i && rd_cmd_i == CMD_READ_VOUT
            && int'(rd_page_i) == g && !vout_valid_i)
            |=> rd_data_o == (((g % 2 == 1) && $past(adc_hires_i[g], 2)) ? {$past(vout_current_i, 2)}
            : $past(vout_l16_i, 2)))
            else $error("output reading does not match last sample");
    end

    AST_WATCHDOG_ALERTS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        watchdog_fault_i && !(|discharge_fault_i) && !(|turn_on_attempt_i) && !(|shutdown_by_line_one_i)
        && !(|shutdown_by_line_zero_i) |=> watchdog_reg && !alert_output_low_o && shutdown_req_o == '0)
        else $error("watchdog fault not flagged with alert, or it turned a channel off");
    AST_ALERT_RELEASE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        alert_output_low_o == !(watchdog_reg || (|alerting_vec)))
        else $error("alert level disagrees with the alerting flags");
    AST_WATCHDOG_HOLDS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        watchdog_reg && !clear_faults_i |=> watchdog_reg)
        else $error("watchdog flag dropped without a clear");
    AST_REVISION_FIXED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rd_req_i && rd_cmd_i == CMD_BUS_REVISION |=> rd_valid_o && rd_data_o == {8'h00, BUS_REVISION_CODE})
        else $error("bus revision read returned wrong value");
    AST_VIN_READBACK: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        vin_valid_i ##1 (rd_req_i && rd_cmd_i == CMD_READ_VIN && !vin_valid_i)
        |=> rd_data_o == {$past(vin_sample_i, 2)})
        else $error("input voltage read does not match last sample");
    AST_TEMP_READBACK: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        temp_valid_i ##1 (rd_req_i && rd_cmd_i == CMD_READ_TEMP && !temp_valid_i)
        |=> rd_data_o == {$past(temp_sample_i, 2)})
        else $error("temperature read does not match last sample");
    AST_STATUS_LIVE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rd_req_i && rd_cmd_i == CMD_VENDOR_STATUS
        |=> rd_data_o[BIT_SERVO_REACHED] == $past(servo_reached_i[rd_page_i])
        && rd_data_o[BIT_DAC_CONNECTED] == $past(dac_connected_i[rd_page_i])
        && rd_data_o[BIT_VINEN_OFF] == $past(vinen_faulted_off_i) && rd_data_o[15:8] == 8'h00)
        else $error("live status bits do not follow their inputs");
    AST_WRITE_REFUSED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        wr_req_i && !rd_req_i |=> wr_refused_o && $stable(rd_data_o))
        else $error("write not refused or read data changed");

endmodule
`default_nettype wire

// file: testbench/host_reader_model.sv
// host_reader_model: host side of the read-back and write ports
// assumes its tasks are called just after a rising edge of clk_i
`timescale 1ns/1ns
`default_nettype none
module host_reader_model (
    input wire logic clk_i,
    output var logic rd_req_o,
    output var logic [2:0] rd_cmd_o,
    output var logic [2:0] rd_page_o,
    output var logic wr_req_o,
    output var logic [2:0] wr_cmd_o
);
    initial begin
        {rd_req_o, rd_cmd_o, rd_page_o, wr_req_o, wr_cmd_o} = '0;
    end
    // request held over the taking edge; selectors scrambled once released; one idle edge follows
    task automatic read(input logic [2:0] c, input logic [2:0] p);
        rd_req_o = 1'b1;
        rd_cmd_o = c;
        rd_page_o = p;
        @(posedge clk_i);
        #1;
        rd_req_o = 1'b0;
        rd_cmd_o = ~c;
        rd_page_o = ~p;
        @(posedge clk_i);
        #1;
    endtask
    task automatic write(input logic [2:0] c);
        wr_req_o = 1'b1;
        wr_cmd_o = c;
        @(posedge clk_i);
        #1;
        wr_req_o = 1'b0;
        wr_cmd_o = ~c;
    endtask
endmodule
`default_nettype wire

// file: testbench/status_telemetry_readback_tb.sv
// status_telemetry_readback_tb: self-checking bench for the read-back block
// assumes host_reader_model drives the read and write ports
`timescale 1ns/1ns
`default_nettype none
module status_telemetry_readback_tb;
    import status_telemetry_pkg::*;
    // arbitrary neutral revision code
    localparam logic [7:0] REV = 8'h2a;
    logic clk_sys_i = 1'b0;
    logic resetn_i, l1, l0, clr, vinen, wdg, vinv, tmpv, voutv, rd_req, wr_req;
    logic [7:0] dis, ton, sd1, sd0, tog, opc, uon, srv, dcn, dsat, doe, f1e, f0e, hir, sdreq;
    logic [2:0] vch, rcmd, rpage, wcmd;
    logic [15:0] l16, rd_data_o;
    l11_s vin_s, tmp_s, cur_s;
    logic rd_valid_o, rd_err_o, wr_refused_o, alert;
    logic [16:0] exp_q[$];
    int miscompares = 0;
    int check_count = 0;
    int seed = 2851;
    always #4 clk_sys_i = ~clk_sys_i;
    status_telemetry_readback #(.CHANNELS(8), .PAGE_W(3), .BUS_REVISION_CODE(REV)) uut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .shared_fault_line_one_i(l1), .shared_fault_line_zero_i(l0),
        .discharge_fault_i(dis), .turn_on_attempt_i(ton),
        .shutdown_by_line_one_i(sd1), .shutdown_by_line_zero_i(sd0),
        .control_toggle_i(tog), .operation_cycle_i(opc), .user_on_cmd_i(uon),
        .clear_faults_i(clr), .servo_reached_i(srv), .dac_connected_i(dcn),
        .dac_saturated_i(dsat), .vinen_faulted_off_i(vinen), .watchdog_fault_i(wdg),
        .discharge_off_en_i(doe), .fault_one_off_en_i(f1e), .fault_zero_off_en_i(f0e),
        .adc_hires_i(hir), .vin_valid_i(vinv), .vin_sample_i(vin_s),
        .temp_valid_i(tmpv), .temp_sample_i(tmp_s), .vout_valid_i(voutv),
        .vout_chan_i(vch), .vout_l16_i(l16), .vout_current_i(cur_s),
        .rd_req_i(rd_req), .rd_cmd_i(rcmd), .rd_page_i(rpage),
        .wr_req_i(wr_req), .wr_cmd_i(wcmd), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .rd_err_o(rd_err_o), .wr_refused_o(wr_refused_o),
        .alert_output_low_o(alert), .shutdown_req_o(sdreq)
    );
    host_reader_model host (
        .clk_i(clk_sys_i), .rd_req_o(rd_req), .rd_cmd_o(rcmd), .rd_page_o(rpage),
        .wr_req_o(wr_req), .wr_cmd_o(wcmd)
    );
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            #1;
        end
    endtask
    task automatic rd(input logic [2:0] c, input logic [2:0] p, input logic [16:0] e);
        exp_q.push_back(e);
        host.read(c, p);
    endtask
    task automatic close_out();
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // answers are compared against the oldest noted expectation
    always @(negedge clk_sys_i) begin
        if (rd_valid_o === 1'b1) begin
            chk({rd_err_o, rd_data_o}, exp_q.pop_front());
        end
    end
    initial begin
        #20000;
        miscompares++;
        close_out();
    end
    initial begin
        {resetn_i, clr, vinen, wdg, vinv, tmpv, voutv, vch, l16, vin_s, tmp_s, cur_s} = '0;
        {dis, ton, sd1, sd0, tog, opc, uon, srv, dcn, dsat, doe, f1e, f0e, hir} = '0;
        {l1, l0} = 2'b11;
        tick(2);
        resetn_i = 1'b1;
        rd(CMD_BUS_REVISION, 3'h0, {9'h000, REV});
        host.write(CMD_BUS_REVISION);
        chk({16'h0000, wr_refused_o}, 17'h00001);
        rd(CMD_BUS_REVISION, 3'h5, {9'h000, REV});
        rd(3'h7, 3'h0, 17'h10000);
        vin_s = l11_s'(16'($random(seed)));
        tmp_s = l11_s'(16'($random(seed)));
        vinv = 1'b1;
        tick(1);
        vinv = 1'b0;
        rd(CMD_READ_VIN, 3'h0, {1'b0, vin_s});
        tmpv = 1'b1;
        tick(1);
        tmpv = 1'b0;
        rd(CMD_READ_TEMP, 3'h0, {1'b0, tmp_s});
        // channel 1 measures current, channel 3 does not, even channels ignore the option
        hir = (8'($random(seed)) | 8'h03) & 8'hf7;
        for (int c = 0; c < 8; c++) begin
            vch = 3'(c);
            l16 = 16'($random(seed));
            cur_s = l11_s'(16'($random(seed)));
            voutv = 1'b1;
            tick(1);
            voutv = 1'b0;
            rd(CMD_READ_VOUT, vch, (c % 2 == 1 && hir[c]) ? {1'b0, cur_s} : {1'b0, l16});
        end
        {srv, dcn, vinen, doe, f0e, dis} = {8'h20, 8'h20, 1'b1, 8'h20, 8'h20, 8'h20};
        tick(1);
        dis = 8'h00;
        chk({8'h00, alert, sdreq}, 17'h00020);
        rd(CMD_VENDOR_STATUS, 3'h5, 17'h0009a);
        rd(CMD_VENDOR_STATUS, 3'h4, 17'h00002);
        l1 = 1'b0;
        tick(3);
        ton = 8'h20;
        tick(1);
        ton = 8'h00;
        chk({9'h000, sdreq}, 17'h00000);
        sd0 = 8'h20;
        tick(1);
        {sd0, l1} = {8'h00, 1'b1};
        chk({9'h000, sdreq}, 17'h00020);
        rd(CMD_VENDOR_STATUS, 3'h5, 17'h000fa);
        tog = 8'h20;
        tick(1);
        tog = 8'h00;
        rd(CMD_VENDOR_STATUS, 3'h5, 17'h0009a);
        {sd1, l0} = {8'h20, 1'b0};
        tick(3);
        {sd1, ton} = {8'h00, 8'h20};
        tick(1);
        {ton, l0} = {8'h00, 1'b1};
        rd(CMD_VENDOR_STATUS, 3'h5, 17'h000fa);
        opc = 8'h20;
        tick(1);
        opc = 8'h00;
        rd(CMD_VENDOR_STATUS, 3'h5, 17'h0009a);
        uon = 8'h20;
        tick(1);
        uon = 8'h00;
        chk({16'h0000, alert}, 17'h00001);
        rd(CMD_VENDOR_STATUS, 3'h5, 17'h0001a);
        dsat = 8'h20;
        tick(1);
        dsat = 8'h00;
        chk({16'h0000, alert}, 17'h00001);
        {srv, dcn, vinen} = {8'h00, 8'h00, 1'b0};
        rd(CMD_VENDOR_STATUS, 3'h5, 17'h00004);
        wdg = 1'b1;
        tick(1);
        wdg = 1'b0;
        chk({8'h00, alert, sdreq}, 17'h00000);
        rd(CMD_VENDOR_STATUS, 3'h2, 17'h00001);
        uon = 8'hff;
        tick(1);
        uon = 8'h00;
        rd(CMD_VENDOR_STATUS, 3'h5, 17'h00001);
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        chk({16'h0000, alert}, 17'h00001);
        rd(CMD_VENDOR_STATUS, 3'h0, 17'h00000);
        wdg = 1'b1;
        tick(1);
        {wdg, resetn_i} = 2'b00;
        tick(1);
        chk({8'h00, alert, sdreq}, 17'h00100);
        resetn_i = 1'b1;
        rd(CMD_VENDOR_STATUS, 3'h0, 17'h00000);
        tick(3);
        chk({16'h0000, exp_q.size() == 0}, 17'h00001);
        close_out();
    end
endmodule
`default_nettype wire
